// ### hw/otg_idle_pkg.sv
// Purpose: constants for the usb module idle handshake and system configuration logic
// Assumes: plain register port, 100 MHz ref_clk
// Notes:   one register only; offset chosen locally
`default_nettype none
package otg_idle_pkg;
    localparam logic [7:0]  SYS_CONFIG_ADDR   = 8'h00;
    localparam int          AUTO_GATE_BIT     = 0;
    localparam int          SW_REINIT_BIT     = 1;
    localparam int          GATED_BIT         = 2;
    localparam int          GRANT_BIT         = 3;
    localparam int          REINIT_BUSY_BIT   = 4;
    localparam logic        AUTO_GATE_RESET   = 1'b1;
    localparam int          REINIT_CYCLES     = 4;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
endpackage
`default_nettype wire

// ### hw/otg_reinit_timer.sv
// Purpose: counts out the software re-initialisation pulse
// Assumes: start is a one-cycle pulse on the same clock
// Notes:   busy stays high for the given number of cycles
`timescale 1ns/1ps
`default_nettype none
module otg_reinit_timer #(
    parameter int CYCLES = 4
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // control
    input  wire logic start,
    output var  logic busy
);
    logic [7:0] count;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 8'h00;
        end else if (start) begin
            count <= 8'(CYCLES);
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= start || (count > 8'h01);
        end
    end
endmodule // otg_reinit_timer
`default_nettype wire

// ### hw/otg_idle_handshake.sv
// Purpose: sleep request/grant handshake and system configuration register
// Assumes: sleep request and module activity come from the same clock domain
// Notes:   read data appear one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module otg_idle_handshake (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // power manager side
    input  wire logic        sleep_req,
    input  wire logic        iface_clk_on,
    input  wire logic        module_busy,
    output var  logic        sleep_grant,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    // status
    output var  logic        clk_gated,
    output var  logic        module_sw_reinit
);
    import otg_idle_pkg::*;

    logic auto_gate;
    logic reinit_busy;
    logic reinit_seen;
    logic access_pending;

    wire sel_cfg      = (reg_addr == SYS_CONFIG_ADDR);
    wire cfg_write    = reg_wr && sel_cfg;
    wire reinit_start = cfg_write && reg_wdata[SW_REINIT_BIT];
    wire any_access   = reg_wr || reg_rd;
    // the grant follows the request level directly, so short pulses never latch it
    wire next_grant   = !iface_clk_on ||
                        (sleep_req && !module_busy && !reg_rd);
    wire next_gated   = auto_gate && !any_access && !access_pending;
    logic [31:0] cfg_view;

    // the reinit bit is write-only, it always reads back as zero
    always_comb begin
        cfg_view                  = UNMAPPED_READ;
        cfg_view[AUTO_GATE_BIT]   = auto_gate;
        cfg_view[SW_REINIT_BIT]   = 1'b0;
        cfg_view[GATED_BIT]       = clk_gated;
        cfg_view[GRANT_BIT]       = sleep_grant;
        cfg_view[REINIT_BUSY_BIT] = reinit_busy;
    end

    otg_reinit_timer #(
        .CYCLES (REINIT_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (reinit_start),
        .busy    (reinit_busy)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            auto_gate <= AUTO_GATE_RESET;
        end else if (reinit_seen && !reinit_busy) begin
            auto_gate <= AUTO_GATE_RESET;
        end else if (cfg_write && !reinit_busy) begin
            auto_gate <= reg_wdata[AUTO_GATE_BIT];
        end
    end

    // remembers a reinit so its end restores the default gating bit
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reinit_seen <= 1'b0;
        end else begin
            reinit_seen <= reinit_start || (reinit_seen && reinit_busy);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            access_pending   <= 1'b0;
            sleep_grant      <= 1'b0;
            clk_gated        <= 1'b0;
            module_sw_reinit <= 1'b0;
            reg_rdata        <= UNMAPPED_READ;
        end else begin
            access_pending   <= any_access;
            sleep_grant      <= next_grant;
            clk_gated        <= next_gated;
            module_sw_reinit <= reinit_busy;
            reg_rdata        <= (reg_rd && sel_cfg) ? cfg_view : UNMAPPED_READ;
        end
    end

    property p_grant_follows;
        @(posedge ref_clk) disable iff (!resetn)
        (sleep_req && iface_clk_on && !module_busy && !reg_rd) |=> sleep_grant;
    endproperty
    a_grant_follows: assert property (p_grant_follows) else $error("grant late");

    property p_grant_drops;
        @(posedge ref_clk) disable iff (!resetn)
        (!sleep_req && iface_clk_on) |=> !sleep_grant;
    endproperty
    a_grant_drops: assert property (p_grant_drops) else $error("grant stuck");

    property p_short_pulse;
        @(posedge ref_clk) disable iff (!resetn)
        (auto_gate && $fell(sleep_req) && iface_clk_on) ##1 (!sleep_req && iface_clk_on)[*2]
        |-> !sleep_grant;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("grant stuck after pulse");

    property p_reinit_restores;
        @(posedge ref_clk) disable iff (!resetn)
        (reinit_start && !reinit_busy) |-> ##[1:8] auto_gate;
    endproperty
    a_reinit_restores: assert property (p_reinit_restores) else $error("gating not restored");

    property p_read_drops;
        @(posedge ref_clk) disable iff (!resetn)
        (reg_rd && iface_clk_on) |=> !sleep_grant && !clk_gated;
    endproperty
    a_read_drops: assert property (p_read_drops) else $error("read kept grant");

    property p_clock_off;
        @(posedge ref_clk) disable iff (!resetn)
        !iface_clk_on |=> sleep_grant;
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("no grant with clock off");

    property p_gate_access;
        @(posedge ref_clk) disable iff (!resetn)
        any_access |=> !clk_gated ##1 !clk_gated;
    endproperty
    a_gate_access: assert property (p_gate_access) else $error("gated during access");

    property p_gate_idle;
        @(posedge ref_clk) disable iff (!resetn)
        (auto_gate && !any_access && !access_pending) |=> clk_gated;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("clock not gated");

    property p_reset_gate;
        @(posedge ref_clk) $rose(resetn) |-> auto_gate;
    endproperty
    a_reset_gate: assert property (p_reset_gate) else $error("reset gating bit wrong");

    // a busy module never grants while its interface clock is on, whatever the request does
    property p_grant_busy;
        @(posedge ref_clk) disable iff (!resetn)
        (module_busy && iface_clk_on) |=> !sleep_grant;
    endproperty
    a_grant_busy: assert property (p_grant_busy) else $error("grant while busy");

    property p_pulse_end;
        @(posedge ref_clk) disable iff (!resetn)
        (auto_gate && sleep_req && iface_clk_on) ##1 (!sleep_req && iface_clk_on)
        |=> !sleep_grant;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("grant held after pulse");

    property p_reset_grant;
        @(posedge ref_clk) $rose(resetn) |-> !sleep_grant && !module_sw_reinit;
    endproperty
    a_reset_grant: assert property (p_reset_grant) else $error("outputs not cleared");

    // repetition count matches the default reinit length
    property p_reinit_pulse;
        @(posedge ref_clk) disable iff (!resetn)
        (reinit_start && !reinit_busy) |-> ##2 module_sw_reinit[*4];
    endproperty
    a_reinit_pulse: assert property (p_reinit_pulse) else $error("reinit short");

    property p_reinit_hold;
        @(posedge ref_clk) disable iff (!resetn)
        reinit_busy |=> $stable(auto_gate);
    endproperty
    a_reinit_hold: assert property (p_reinit_hold) else $error("gating moved");

    property p_restore_end;
        @(posedge ref_clk) disable iff (!resetn)
        (reinit_seen && !reinit_busy) |=> auto_gate;
    endproperty
    a_restore_end: assert property (p_restore_end) else $error("not restored");

    property p_rdata_idle;
        @(posedge ref_clk) disable iff (!resetn)
        !reg_rd |=> (reg_rdata == UNMAPPED_READ);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");

    // a read must not wake a module whose interface clock is off
    property p_read_clock_off;
        @(posedge ref_clk) disable iff (!resetn)
        (reg_rd && !iface_clk_on) |=> sleep_grant;
    endproperty
    a_read_clock_off: assert property (p_read_clock_off) else $error("grant lost");

    property p_gate_off;
        @(posedge ref_clk) disable iff (!resetn)
        !auto_gate |=> !clk_gated;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gated while disabled");

    property p_gate_restart;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_gated && any_access) |=> !clk_gated;
    endproperty
    a_gate_restart: assert property (p_gate_restart) else $error("not restarted");

    c_grant: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(sleep_grant));
    c_short: cover property (@(posedge ref_clk) disable iff (!resetn)
        auto_gate && $rose(sleep_req) ##1 $fell(sleep_req));
    c_reinit: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(module_sw_reinit));
    c_gated: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(clk_gated));
    c_clock_off: cover property (@(posedge ref_clk) disable iff (!resetn)
        $fell(iface_clk_on) ##1 sleep_grant);
endmodule // otg_idle_handshake
`default_nettype wire

// ### verif/pm_model.sv
// Purpose: power manager model issuing sleep request pulses
// Assumes: same clock as the block
// Notes:   one pulse of len cycles per go
`timescale 1ns/1ps
`default_nettype none
module pm_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // bench control
    input  wire logic       go,
    input  wire logic [2:0] len,
    // handshake
    input  wire logic       sleep_grant,
    output var  logic       sleep_req
);
    logic [2:0] cnt;
    assign sleep_req = (cnt != 3'h0);
    // a stuck grant blocks the next request
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) cnt <= 3'h0;
        else if (go && !sleep_grant && !sleep_req) cnt <= len;
        else if (sleep_req) cnt <= cnt - 3'h1;
    end
endmodule // pm_model
`default_nettype wire

// ### verif/usb_otg_idle_handshake_sysconfig_tb.sv
// Purpose: self-checking bench for the idle handshake block
// Assumes: read data one cycle after the read strobe
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`default_nettype none
module usb_otg_idle_handshake_sysconfig_tb;
    import otg_idle_pkg::*;
    logic        ref_clk = 1'b0, resetn = 1'b0, go = 1'b0, iface_clk_on = 1'b1;
    logic        module_busy = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
    logic        sleep_req, sleep_grant, clk_gated, module_sw_reinit;
    logic [2:0]  len = 3'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, seed = 32'h0000_0038, exp_q[$];
    int          n_errors = 0, checks = 0;
    always #5 ref_clk = ~ref_clk;
    otg_idle_handshake i_otg_idle_handshake (.ref_clk(ref_clk), .resetn(resetn),
        .sleep_req(sleep_req), .iface_clk_on(iface_clk_on), .module_busy(module_busy),
        .sleep_grant(sleep_grant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_gated(clk_gated),
        .module_sw_reinit(module_sw_reinit));
    pm_model i_pm_model (.ref_clk(ref_clk), .resetn(resetn), .go(go), .len(len),
        .sleep_grant(sleep_grant), .sleep_req(sleep_req));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // strobe is lowered one edge later, so calls never collide
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    // gated and grant bits left out of the read compare
    always @(posedge ref_clk) rd_q <= reg_rd;
    always @(negedge ref_clk) if (rd_q) begin
        check("rdata", exp_q.pop_front(), reg_rdata & 32'h13);
        if (iface_clk_on) check("grant after read", 32'h0, 32'(sleep_grant));
        check("clock after read", 32'h0, 32'(clk_gated));
    end
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(SYS_CONFIG_ADDR, 32'h1);
        wr(SYS_CONFIG_ADDR, 32'h0);
        rd(SYS_CONFIG_ADDR, 32'h0);
        wr(SYS_CONFIG_ADDR, 32'h2);
        @(negedge ref_clk);
        check("reinit", 32'h1, 32'(module_sw_reinit));
        repeat (5) @(posedge ref_clk);
        rd(SYS_CONFIG_ADDR, 32'h1);
        wr(SYS_CONFIG_ADDR, 32'h3);
        rd(SYS_CONFIG_ADDR, 32'h11);
        seed = xs(seed);
        wr({1'b1, seed[6:0]}, seed);
        rd({1'b1, seed[6:0]}, 32'h0);
        rd(SYS_CONFIG_ADDR, 32'h1);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            len <= {1'b0, seed[1:0]} + 3'h1;
            module_busy <= seed[2];
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (2) @(negedge ref_clk);
            check("grant", 32'(!module_busy), 32'(sleep_grant));
            repeat (int'(len)) @(negedge ref_clk);
            check("release", 32'h0, 32'(sleep_grant));
            @(posedge ref_clk);
        end
        module_busy <= 1'b0;
        len <= 3'h7;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        rd(SYS_CONFIG_ADDR, 32'h1);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        check("gated", 32'h1, 32'(clk_gated));
        @(posedge ref_clk);
        wr(SYS_CONFIG_ADDR, 32'h0);
        repeat (3) @(negedge ref_clk);
        check("ungated", 32'h0, 32'(clk_gated));
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(SYS_CONFIG_ADDR, 32'h1);
        iface_clk_on <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("clock off", 32'h1, 32'(sleep_grant));
        @(posedge ref_clk);
        rd(SYS_CONFIG_ADDR, 32'h1);
        @(negedge ref_clk);
        check("clock off read", 32'h1, 32'(sleep_grant));
        stop_test();
    end
endmodule // usb_otg_idle_handshake_sysconfig_tb
`default_nettype wire
